/* File: hw/mau_pkg.sv */
package mau_pkg;

   // ---------------------------------------------------------------
   // special function register addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] MAU_ADDR_CTRL1 = 8'heb;
   localparam logic [7:0] MAU_ADDR_CTRL2 = 8'hf1;
   localparam logic [7:0] MAU_ADDR_A0 = 8'hf2;
   localparam logic [7:0] MAU_ADDR_A1 = 8'hf3;
   localparam logic [7:0] MAU_ADDR_B0 = 8'hf9;
   localparam logic [7:0] MAU_ADDR_B1 = 8'hfa;
   localparam logic [7:0] MAU_ADDR_C0 = 8'hec;
   localparam logic [7:0] MAU_ADDR_RES0 = 8'hf4;
   localparam int MAU_C_BYTES = 4;
   localparam int MAU_RES_BYTES = 4;

   // ---------------------------------------------------------------
   // field positions of the second control register
   // ---------------------------------------------------------------
   localparam int MAU_CLR_MSB = 7;
   localparam int MAU_CLR_LSB = 5;
   localparam int MAU_IE_BIT = 4;
   localparam int MAU_OV16_BIT = 1;
   localparam int MAU_OV32_BIT = 0;

   // ---------------------------------------------------------------
   // values after reset
   // ---------------------------------------------------------------
   localparam logic [7:0] MAU_CTRL1_RST = 8'h00;
   localparam logic [15:0] MAU_OPND16_RST = 16'h0000;
   localparam logic [31:0] MAU_WORD32_RST = 32'h0000_0000;
   localparam logic [7:0] MAU_RDATA_RST = 8'h00;

   // ---------------------------------------------------------------
   // control fields and commands
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      MAU_MUL_AB = 2'h0,
      MAU_MUL_AA = 2'h1,
      MAU_MUL_APREV = 2'h2,
      MAU_MUL_AB2 = 2'h3
   } mau_multiply_command_field_t;

   typedef enum logic [1:0] {
      MAU_ADD_ZERO = 2'h0,
      MAU_ADD_C = 2'h1,
      MAU_ADD_PREV = 2'h2,
      MAU_ADD_CAT = 2'h3
   } mau_addition_source_field_t;

   typedef enum logic [2:0] {
      MAU_CLR_NONE = 3'h0,
      MAU_CLR_A = 3'h1,
      MAU_CLR_B = 3'h2,
      MAU_CLR_C = 3'h3,
      MAU_CLR_PREV = 3'h4,
      MAU_CLR_ALL = 3'h5,
      MAU_CLR_FLAGS = 3'h6,
      MAU_CLR_NONE2 = 3'h7
   } mau_clear_t;

   typedef struct packed {
      logic manual_capture_trigger;
      logic capture_method_select;
      logic overflow_sticky_select;
      logic result_override_select;
      mau_addition_source_field_t addition_source_field;
      mau_multiply_command_field_t multiply_command_field;
   } mau_ctrl1_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mau_sfr_req_t;

endpackage

/* File: hw/mau_arith.sv */
`timescale 1ns/100ps
module mau_arith (
   // operands
   input wire logic [15:0] operand_a_i,
   input wire logic [15:0] operand_b_i,
   input wire logic [31:0] addend_c_i,
   input wire logic [31:0] prior_i,
   // selects
   input wire mau_pkg::mau_multiply_command_field_t mul_i,
   input wire mau_pkg::mau_addition_source_field_t add_i,
   // results
   output logic [31:0] raw_o,
   output logic ov32_o,
   output logic ov16_o
);
   import mau_pkg::*;

   logic signed [15:0] mul_b;
   logic signed [31:0] product;
   logic signed [31:0] add_a;
   logic signed [31:0] add_b;
   logic signed [32:0] sum;

   // ---------------------------------------------------------------
   // multiplier and adder, purely combinational
   // ---------------------------------------------------------------
   always_comb begin
      case (mul_i)
         MAU_MUL_AA: mul_b = operand_a_i;
         MAU_MUL_APREV: mul_b = prior_i[15:0];
         default: mul_b = operand_b_i;
      endcase
      product = 32'($signed(operand_a_i)) * 32'(mul_b);
      // a is the upper half of the joined word
      add_a = (add_i == MAU_ADD_CAT) ? {operand_a_i, operand_b_i} : product;
      case (add_i)
         MAU_ADD_ZERO: add_b = 32'sh0000_0000;
         MAU_ADD_PREV: add_b = prior_i;
         default: add_b = addend_c_i;
      endcase
      sum = {add_a[31], add_a} + {add_b[31], add_b};
   end

   assign raw_o = sum[31:0];
   assign ov32_o = sum[32] ^ sum[31];
   assign ov16_o = ~((&sum[32:15]) | ~(|sum[32:15]));

endmodule

/* File: hw/mau_core.sv */
// Function
// - result follows operands at once, no start or wait
// - operands are signed two's complement; unsigned needs 15-bit magnitudes
// - a and b are 16 bits, addend and result 32 bits
// - capture method 0: writing the low byte of a captures result into prior
// - capture method 1: writing 1 to trigger captures result into prior
// - overflow flags live when sticky select 0, held until cleared when 1
// - addition source picks zero, addend c, or prior result
// - addition source 11 feeds joined a:b instead of product
// - multiply command picks a*b, a*a or a*prior low half
// - clear field zeroes a, b, c, prior, everything, or flags
// - interrupt when wide overflow flag set and its enable set
// - narrow overflow flag set on 16-bit overflow, else reads 0 when sticky select 0
// - wide overflow flag setting captures low result word
// - joined word has a as upper half, b as lower half
// - prior register takes the result register contents
// - result register is the shifter output after multiply-add, or the overflow capture word when override select is 1
`timescale 1ns/100ps
module mau_core (
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // special function register port
   input wire mau_pkg::mau_sfr_req_t sfr_i,
   output logic [7:0] sfr_rdata_o,
   // status
   output logic irq_o,
   output logic [31:0] prior_result_o,
   output logic [31:0] overflow_capture_o
);
   import mau_pkg::*;

   mau_ctrl1_t ctrl1;
   logic wide_overflow_irq_enable;
   logic narrow_overflow_flag;
   logic wide_overflow_flag;
   logic [15:0] operand_a_reg;
   logic [15:0] operand_b_reg;
   logic [31:0] addend_c_reg;
   logic [31:0] prior_result_reg;
   logic [31:0] overflow_capture_reg;
   logic [31:0] raw_sum;
   logic [31:0] result_term;
   logic ov32_cond;
   logic ov16_cond;
   logic wr_ctrl1;
   logic wr_ctrl2;
   logic wr_a0;
   mau_clear_t clr_code;
   logic clr_a;
   logic clr_b;
   logic clr_c;
   logic clr_prev;
   logic clr_flags;
   logic capture_prior;
   logic next_wide_flag;
   logic next_narrow_flag;
   logic [7:0] next_rdata;

   // ---------------------------------------------------------------
   // datapath
   // ---------------------------------------------------------------
   mau_arith u_arith (
      .operand_a_i(operand_a_reg),
      .operand_b_i(operand_b_reg),
      .addend_c_i(addend_c_reg),
      .prior_i(prior_result_reg),
      .mul_i(ctrl1.multiply_command_field),
      .add_i(ctrl1.addition_source_field),
      .raw_o(raw_sum),
      .ov32_o(ov32_cond),
      .ov16_o(ov16_cond)
   );

   // result seen by software; shifter stage passes it through unshifted
   assign result_term = ctrl1.result_override_select ? overflow_capture_reg : raw_sum;

   // ---------------------------------------------------------------
   // write decode and one-shot commands
   // ---------------------------------------------------------------
   assign wr_ctrl1 = ce_i & sfr_i.wr & (sfr_i.addr == MAU_ADDR_CTRL1);
   assign wr_ctrl2 = ce_i & sfr_i.wr & (sfr_i.addr == MAU_ADDR_CTRL2);
   assign wr_a0 = ce_i & sfr_i.wr & (sfr_i.addr == MAU_ADDR_A0);
   // code is never stored, so each clear happens once per write
   assign clr_code = mau_clear_t'(sfr_i.wdata[MAU_CLR_MSB:MAU_CLR_LSB]);
   assign clr_a = wr_ctrl2 & (clr_code == MAU_CLR_A || clr_code == MAU_CLR_ALL);
   assign clr_b = wr_ctrl2 & (clr_code == MAU_CLR_B || clr_code == MAU_CLR_ALL);
   assign clr_c = wr_ctrl2 & (clr_code == MAU_CLR_C || clr_code == MAU_CLR_ALL);
   assign clr_prev = wr_ctrl2 & (clr_code == MAU_CLR_PREV || clr_code == MAU_CLR_ALL);
   assign clr_flags = wr_ctrl2 & (clr_code == MAU_CLR_FLAGS || clr_code == MAU_CLR_ALL);
   assign capture_prior = (wr_a0 & ~ctrl1.capture_method_select)
      | (wr_ctrl1 & sfr_i.wdata[7] & sfr_i.wdata[6]);

   // ---------------------------------------------------------------
   // control registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl1 <= mau_ctrl1_t'(MAU_CTRL1_RST);
         wide_overflow_irq_enable <= 1'b0;
      end else begin
         if (wr_ctrl1) begin
            // trigger bit acts only on the write and reads back as 0
            ctrl1 <= mau_ctrl1_t'({1'b0, sfr_i.wdata[6:0]});
         end
         if (wr_ctrl2) begin
            wide_overflow_irq_enable <= sfr_i.wdata[MAU_IE_BIT];
         end
      end
   end

   // ---------------------------------------------------------------
   // operand registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         operand_a_reg <= MAU_OPND16_RST;
         operand_b_reg <= MAU_OPND16_RST;
         addend_c_reg <= MAU_WORD32_RST;
      end else if (ce_i) begin
         if (clr_a) begin
            operand_a_reg <= MAU_OPND16_RST;
         end else if (sfr_i.wr && sfr_i.addr == MAU_ADDR_A0) begin
            operand_a_reg[7:0] <= sfr_i.wdata;
         end else if (sfr_i.wr && sfr_i.addr == MAU_ADDR_A1) begin
            operand_a_reg[15:8] <= sfr_i.wdata;
         end
         if (clr_b) begin
            operand_b_reg <= MAU_OPND16_RST;
         end else if (sfr_i.wr && sfr_i.addr == MAU_ADDR_B0) begin
            operand_b_reg[7:0] <= sfr_i.wdata;
         end else if (sfr_i.wr && sfr_i.addr == MAU_ADDR_B1) begin
            operand_b_reg[15:8] <= sfr_i.wdata;
         end
         if (clr_c) begin
            addend_c_reg <= MAU_WORD32_RST;
         end else begin
            for (int i = 0; i < MAU_C_BYTES; i++) begin
               if (sfr_i.wr && sfr_i.addr == MAU_ADDR_C0 + 8'(i)) begin
                  addend_c_reg[i*8 +: 8] <= sfr_i.wdata;
               end
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // prior result and overflow capture
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prior_result_reg <= MAU_WORD32_RST;
      end else if (capture_prior) begin
         prior_result_reg <= result_term;
      end else if (clr_prev) begin
         prior_result_reg <= MAU_WORD32_RST;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         overflow_capture_reg <= MAU_WORD32_RST;
      end else if (ce_i && ov32_cond && !wide_overflow_flag) begin
         overflow_capture_reg <= raw_sum;
      end else if (ce_i && wr_ctrl2 && clr_code == MAU_CLR_ALL) begin
         overflow_capture_reg <= MAU_WORD32_RST;
      end
   end

   // ---------------------------------------------------------------
   // overflow flags; a new overflow wins over a clear
   // ---------------------------------------------------------------
   always_comb begin
      if (ctrl1.overflow_sticky_select) begin
         next_wide_flag = ov32_cond | (wide_overflow_flag & ~clr_flags);
         next_narrow_flag = ov16_cond | (narrow_overflow_flag & ~clr_flags);
      end else begin
         next_wide_flag = ov32_cond;
         next_narrow_flag = ov16_cond;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wide_overflow_flag <= 1'b0;
         narrow_overflow_flag <= 1'b0;
      end else if (ce_i) begin
         wide_overflow_flag <= next_wide_flag;
         narrow_overflow_flag <= next_narrow_flag;
      end
   end

   assign irq_o = wide_overflow_flag & wide_overflow_irq_enable;
   assign prior_result_o = prior_result_reg;
   assign overflow_capture_o = overflow_capture_reg;

   // ---------------------------------------------------------------
   // read port, one cycle after the read strobe
   // ---------------------------------------------------------------
   always_comb begin
      next_rdata = 8'h00;
      if (sfr_i.addr == MAU_ADDR_CTRL1) begin
         next_rdata = ctrl1;
      end else if (sfr_i.addr == MAU_ADDR_CTRL2) begin
         next_rdata = {3'h0, wide_overflow_irq_enable, 2'h0, narrow_overflow_flag,
                       wide_overflow_flag};
      end else if (sfr_i.addr == MAU_ADDR_A0) begin
         next_rdata = operand_a_reg[7:0];
      end else if (sfr_i.addr == MAU_ADDR_A1) begin
         next_rdata = operand_a_reg[15:8];
      end else if (sfr_i.addr == MAU_ADDR_B0) begin
         next_rdata = operand_b_reg[7:0];
      end else if (sfr_i.addr == MAU_ADDR_B1) begin
         next_rdata = operand_b_reg[15:8];
      end else begin
         for (int i = 0; i < MAU_RES_BYTES; i++) begin
            if (sfr_i.addr == MAU_ADDR_C0 + 8'(i)) begin
               next_rdata = addend_c_reg[i*8 +: 8];
            end
            if (sfr_i.addr == MAU_ADDR_RES0 + 8'(i)) begin
               next_rdata = result_term[i*8 +: 8];
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sfr_rdata_o <= MAU_RDATA_RST;
      end else if (ce_i && sfr_i.rd) begin
         sfr_rdata_o <= next_rdata;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   auto_capture_a: assert property (wr_a0 && !ctrl1.capture_method_select |=>
      prior_result_reg == $past(result_term)) else $error("auto capture missed");
   manual_capture_a: assert property (wr_ctrl1 && sfr_i.wdata[7:6] == 2'h3 |=>
      prior_result_reg == $past(result_term) && !ctrl1.manual_capture_trigger)
      else $error("manual capture missed");
   live_flag_a: assert property (ce_i && !ctrl1.overflow_sticky_select |=>
      wide_overflow_flag == $past(ov32_cond)) else $error("live flag wrong");
   sticky_hold_a: assert property (ctrl1.overflow_sticky_select && wide_overflow_flag
      && !clr_flags |=> wide_overflow_flag) else $error("sticky flag dropped");
   ov_capture_a: assert property (ce_i && ov32_cond && !wide_overflow_flag |=>
      overflow_capture_reg == $past(raw_sum) && wide_overflow_flag)
      else $error("overflow word not captured");
   clear_a_a: assert property (clr_a |=> operand_a_reg == 16'h0000)
      else $error("operand a not cleared");
   irq_rise_a: assert property (ce_i && ov32_cond && wide_overflow_irq_enable
      && !wr_ctrl2 |=> irq_o) else $error("interrupt not raised");
   read_result_a: assert property (ce_i && sfr_i.rd && sfr_i.addr == MAU_ADDR_RES0 |=>
      sfr_rdata_o == $past(result_term[7:0])) else $error("result byte read wrong");
   narrow_flag_a: assert property (ce_i && !ov16_cond && !ctrl1.overflow_sticky_select |=>
      !narrow_overflow_flag) else $error("narrow flag set without overflow");

endmodule

/* File: sim/tb.sv */
`timescale 1ns/100ps
module tb;
   import mau_pkg::*;

   // ---------------------------------------------------------------
   // signals and design
   // ---------------------------------------------------------------
   typedef struct {
      logic [7:0] ctrl;
      logic [15:0] a;
      logic [15:0] b;
      logic [31:0] c;
      logic [31:0] res;
      logic [7:0] stat;
   } mau_row_t;

   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce_i = 1'b1;
   mau_sfr_req_t sfr_i = '0;
   logic [7:0] sfr_rdata_o;
   logic irq_o;
   logic [31:0] prior_result_o;
   logic [31:0] overflow_capture_o;
   int err_count = 0;
   int checks = 0;
   logic [31:0] word;
   logic [2:0] clr_code [4] = '{3'h7, 3'h1, 3'h2, 3'h3};
   logic [7:0] clr_addr [4] = '{8'hf3, 8'hf3, 8'hfa, 8'hef};
   logic [7:0] clr_exp [4] = '{8'h12, 8'h00, 8'h00, 8'h00};
   // manual capture method in every row keeps the prior register at zero
   mau_row_t rows [8] = '{
      '{8'h40, 16'h0003, 16'h0005, 32'h0, 32'h0000_000f, 8'h00},
      '{8'h41, 16'hfffe, 16'h0007, 32'h0, 32'h0000_0004, 8'h00},
      '{8'h44, 16'h0100, 16'h0100, 32'h10, 32'h0001_0010, 8'h02},
      '{8'h4c, 16'h1234, 16'h5678, 32'h1, 32'h1234_5679, 8'h02},
      '{8'h43, 16'hfffd, 16'h0004, 32'h0, 32'hffff_fff4, 8'h00},
      '{8'h48, 16'h7fff, 16'h7fff, 32'h0, 32'h3fff_0001, 8'h02},
      '{8'h42, 16'h0005, 16'h0005, 32'h0, 32'h0000_0000, 8'h00},
      '{8'h4d, 16'hffff, 16'hffff, 32'h2, 32'h0000_0001, 8'h00}};

   always #2.5 clk_i = ~clk_i;

   mau_core mau_core_i (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .sfr_i(sfr_i),
      .sfr_rdata_o(sfr_rdata_o),
      .irq_o(irq_o),
      .prior_result_o(prior_result_o),
      .overflow_capture_o(overflow_capture_o)
   );

   // ---------------------------------------------------------------
   // bus tasks and checks
   // ---------------------------------------------------------------
   task automatic xfer(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      sfr_i = '{w, r, a, d};
      @(posedge clk_i);
      #1;
   endtask

   // the idle cycle keeps a held strobe from writing twice
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(1'b1, 1'b0, a, d);
      xfer(1'b0, 1'b0, a, d);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
         err_count++;
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      xfer(1'b0, 1'b1, a, 8'h00);
      chk({24'h0, sfr_rdata_o}, {24'h0, exp});
   endtask

   task automatic rd_res(input logic [31:0] exp);
      for (int i = 0; i < MAU_RES_BYTES; i++) begin
         xfer(1'b0, 1'b1, MAU_ADDR_RES0 + 8'(i), 8'h00);
         word[8*i+:8] = sfr_rdata_o;
      end
      chk(word, exp);
   endtask

   task automatic load(input logic [15:0] a, input logic [15:0] b, input logic [31:0] c);
      wr(MAU_ADDR_A0, a[7:0]);
      wr(MAU_ADDR_A1, a[15:8]);
      wr(MAU_ADDR_B0, b[7:0]);
      wr(MAU_ADDR_B1, b[15:8]);
      for (int i = 0; i < MAU_C_BYTES; i++) begin
         wr(MAU_ADDR_C0 + 8'(i), c[8*i+:8]);
      end
   endtask

   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk_i);
      err_count++;
      finish_test();
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clk_i);
      #1;
      rst_i = 1'b0;
      chk({31'h0, irq_o}, 32'h0);
      chk(prior_result_o, MAU_WORD32_RST);
      chk(overflow_capture_o, MAU_WORD32_RST);
      rd(MAU_ADDR_CTRL1, MAU_CTRL1_RST);
      $display("test reset done");
      foreach (rows[i]) begin
         wr(MAU_ADDR_CTRL1, rows[i].ctrl);
         load(rows[i].a, rows[i].b, rows[i].c);
         rd_res(rows[i].res);
         rd(MAU_ADDR_CTRL2, rows[i].stat);
      end
      $display("test table done");
      wr(MAU_ADDR_CTRL1, 8'h00);
      load(16'h0003, 16'h0005, 32'h0);
      wr(MAU_ADDR_A0, 8'h02);
      chk(prior_result_o, 32'd15);
      wr(MAU_ADDR_CTRL1, 8'h02);
      rd_res(32'd30);
      wr(MAU_ADDR_CTRL1, 8'h40);
      wr(MAU_ADDR_A0, 8'h04);
      chk(prior_result_o, 32'd15);
      wr(MAU_ADDR_CTRL1, 8'hc0);
      chk(prior_result_o, 32'd20);
      rd(MAU_ADDR_CTRL1, 8'h40);
      wr(MAU_ADDR_CTRL1, 8'h48);
      rd_res(32'd40);
      wr(8'h80, 8'h5a);
      rd(8'h80, 8'h00);
      wr(MAU_ADDR_RES0, 8'hff);
      rd_res(32'd40);
      $display("test capture done");
      load(16'h1234, 16'h5678, 32'h9abc_def0);
      for (int i = 0; i < 4; i++) begin
         wr(MAU_ADDR_CTRL2, {clr_code[i], 5'h00});
         rd(clr_addr[i], clr_exp[i]);
      end
      wr(MAU_ADDR_CTRL2, 8'h80);
      chk(prior_result_o, 32'h0);
      wr(MAU_ADDR_A1, 8'h55);
      rd(MAU_ADDR_A1, 8'h55);
      $display("test clear done");
      wr(MAU_ADDR_CTRL1, 8'h64);
      wr(MAU_ADDR_CTRL2, 8'h10);
      load(16'h7fff, 16'h7fff, 32'h7fff_ffff);
      chk(overflow_capture_o, 32'hbfff_0000);
      rd(MAU_ADDR_CTRL2, 8'h13);
      chk({31'h0, irq_o}, 32'h1);
      wr(MAU_ADDR_CTRL2, 8'h70);
      rd(MAU_ADDR_CTRL2, 8'h13);
      wr(MAU_ADDR_CTRL1, 8'h74);
      rd_res(32'hbfff_0000);
      wr(MAU_ADDR_CTRL1, 8'h64);
      rd_res(32'h3fff_0001);
      wr(MAU_ADDR_CTRL2, 8'hd0);
      rd(MAU_ADDR_CTRL2, 8'h12);
      chk({31'h0, irq_o}, 32'h0);
      // old operands still overflow 16 bits on the clear edge, and a set beats a clear
      wr(MAU_ADDR_CTRL2, 8'ha0);
      rd(MAU_ADDR_CTRL2, 8'h02);
      wr(MAU_ADDR_CTRL2, 8'hc0);
      rd(MAU_ADDR_CTRL2, 8'h00);
      chk(prior_result_o, 32'h0);
      chk(overflow_capture_o, 32'h0);
      rd_res(32'h0);
      $display("test overflow done");
      wr(MAU_ADDR_CTRL1, 8'h40);
      load(16'h7fff, 16'h7fff, 32'h0);
      rd(MAU_ADDR_CTRL2, 8'h02);
      wr(MAU_ADDR_CTRL2, 8'h40);
      rd(MAU_ADDR_CTRL2, 8'h00);
      ce_i = 1'b0;
      wr(MAU_ADDR_A1, 8'h11);
      ce_i = 1'b1;
      rd(MAU_ADDR_A1, 8'h7f);
      // leave a nonzero prior word so the second reset has something to clear
      wr(MAU_ADDR_B0, 8'h02);
      wr(MAU_ADDR_CTRL1, 8'hc0);
      chk(prior_result_o, 32'h0000_fffe);
      rst_i = 1'b1;
      repeat (2) xfer(1'b0, 1'b0, 8'h00, 8'h00);
      rst_i = 1'b0;
      rd(MAU_ADDR_CTRL1, MAU_CTRL1_RST);
      rd(MAU_ADDR_A1, 8'h00);
      chk(prior_result_o, MAU_WORD32_RST);
      $display("test flags and second reset done");
      finish_test();
   end
endmodule
